// [rtl/angle_pwm_pkg.sv]
package angle_pwm_pkg;
  // clock
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  // angle refresh and latency
  localparam int ANG_REFRESH_NS = 1000;
  localparam int ANG_REFRESH_CYC = (ANG_REFRESH_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATENCY_US = 10;
  localparam int LATENCY_STAGES = LATENCY_US * 1000 / ANG_REFRESH_NS;
  // serial latch after chip select falls (longest time, rounded down)
  localparam int CS_LATCH_NS = 125;
  localparam int CS_LATCH_CYC = (CS_LATCH_NS / CLK_NS < 1) ? 1 : CS_LATCH_NS / CLK_NS;
  localparam int SERIAL_BITS = 16;
  // slow register refresh
  localparam int ZCD_US = 32;
  localparam int ZCD_CYC = ZCD_US * 1000 / CLK_NS;
  localparam int FIELD_US = 128;
  localparam int FIELD_CYC = FIELD_US * 1000 / CLK_NS;
  // widths
  localparam int ANG_W = 15;
  localparam int PWM_ANG_W = 12;
  localparam int FAULT_N = 13;
  localparam int CFG_W = 12;
  localparam int PER_W = 20;
  localparam int NUM_W = 17;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WPTR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ANGLE = 8'h0c;
  localparam logic [7:0] OFS_ZCD = 8'h10;
  localparam logic [7:0] OFS_FIELD = 8'h14;
  // control field positions
  localparam int CTRL_EOE = 0;
  localparam int CTRL_ESS = 1;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_BAND_LSB = 4;
  localparam int CTRL_STEP_LSB = 8;
  localparam logic [7:0] WPTR_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // duty in units of 1/100000 of the period
  localparam int PCT_SCALE = 100000;
  localparam logic [NUM_W-1:0] DUTY_LOW = 17'd5000;
  localparam logic [NUM_W-1:0] DUTY_SPAN = 17'd90000;
  localparam logic [NUM_W-1:0] ERR_BASE = 17'd5000;
  localparam logic [NUM_W-1:0] ERR_STEP = 17'd5625;
  // carrier period = band base + step * band increment, in clock cycles
  localparam int STEP_INC0 = 100;
  typedef logic [PER_W-1:0] per_t;
  function automatic per_t band_base(input logic [2:0] band);
    case (band)
      3'h0: band_base = 20'd12800;
      3'h1: band_base = 20'd14400;
      3'h2: band_base = 20'd17600;
      3'h3: band_base = 20'd24000;
      3'h4: band_base = 20'd36800;
      3'h5: band_base = 20'd62400;
      3'h6: band_base = 20'd113600;
      default: band_base = 20'd216000;
    endcase
  endfunction : band_base
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_LATCH = 2'b01,
    SER_SHIFT = 2'b10,
    SER_DONE = 2'b11
  } ser_state_t;
endpackage : angle_pwm_pkg

// [rtl/pwm_carrier.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_carrier
  import angle_pwm_pkg::*;
#(
  parameter int W = PER_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // next period setting, taken at each period start
  input wire logic [W-1:0] period_len,
  input wire logic [W-1:0] fall_point,
  // output
  output logic pwm_level,
  output logic period_start
);
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] per_q, fall_q;
  wire wrap = (cnt_q >= per_q - W'(1));
  wire [W-1:0] fall_eff = wrap ? fall_point : fall_q;

  assign cnt_d = wrap ? '0 : cnt_q + W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      per_q <= W'(12800);
      fall_q <= '0;
      pwm_level <= 1'b0;
      period_start <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      period_start <= wrap;
      if (wrap) begin
        per_q <= period_len;
        fall_q <= fall_point;
      end
      pwm_level <= (cnt_d < fall_eff);
    end
  end
endmodule : pwm_carrier
`default_nettype wire

// [rtl/angle_pwm_output.sv]
// Functional notes
// - serial angle: 12-bit plus flags, or 15-bit
// - one serial readout is sixteen clocks
// - pulse output always uses 12-bit angle
// - angle registers refresh every microsecond
// - processed angle lags sample by ten microseconds
// - encoder outputs refresh per interval, on change
// - latch serial data within 125 ns
// - zero-cross 32 us, field 128 us refresh
// - power-up reloads shadow bits, registers default
// - write pointer cleared at power-up
// - duty clamped between 5% and 95%
// - 0% and 100% reserved for errors
// - fixed rising edge, falling edge moves
// - error enable lets errors reach pin
// - select 0: error tristates the pin
// - tristate holds until next power cycle
// - select 1: halve frequency during error
// - brief errors shown once next period (with select 1 the code shows them once, in the period after next)
// - error duty by priority, 5% to 72.5%
// - carrier from band and step fields
`timescale 1ns/1ps
`default_nettype none
module angle_pwm_output
  import angle_pwm_pkg::*;
#(
  parameter int FIELD_REFRESH_CYC = FIELD_CYC,
  parameter int LAT_STAGES = LATENCY_STAGES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // nonvolatile configuration and data path inputs
  input wire logic [CFG_W-1:0] nvm_config,
  input wire logic [ANG_W-1:0] angle_raw,
  input wire logic [11:0] zero_cross_raw,
  input wire logic [11:0] field_raw,
  input wire logic [FAULT_N-1:0] fault_flags,
  // serial readout pins
  input wire logic cs_n,
  input wire logic sclk,
  output logic miso,
  // pulse-width pin
  output logic pwm_out,
  output logic pwm_oe,
  // incremental and commutation feed
  output logic [ANG_W-1:0] encoder_angle,
  output logic encoder_update
);
  localparam int FW = $clog2(FIELD_REFRESH_CYC + 1);
  localparam int ZW = $clog2(ZCD_CYC + 1);
  localparam int AW = $clog2(ANG_REFRESH_CYC + 1);

  // ---------------- registers
  logic [CFG_W-1:0] ctrl_q;
  logic [7:0] wptr_q;
  logic [11:0] zero_cross_angle_value_q, field_q;
  logic hiz_q;

  wire error_output_enable = ctrl_q[CTRL_EOE];
  wire error_signal_select = ctrl_q[CTRL_ESS];
  wire angle_wide = ctrl_q[CTRL_WIDE];
  wire [2:0] carrier_band_select = ctrl_q[CTRL_BAND_LSB +: 3];
  wire [3:0] carrier_step_select = ctrl_q[CTRL_STEP_LSB +: 4];

  // ---------------- angle refresh and latency line
  logic [AW-1:0] ang_cnt_q;
  logic [ANG_W-1:0] pipe_q [LAT_STAGES];
  wire ang_tick = (ang_cnt_q == AW'(ANG_REFRESH_CYC - 1));
  wire [ANG_W-1:0] angle_now = pipe_q[LAT_STAGES-1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ang_cnt_q <= '0;
    end else begin
      ang_cnt_q <= ang_tick ? '0 : ang_cnt_q + AW'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LAT_STAGES; gi++) begin : g_lat
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pipe_q[gi] <= '0;
        end else if (ang_tick) begin
          if (gi == 0) begin
            pipe_q[gi] <= angle_raw;
          end else begin
            pipe_q[gi] <= pipe_q[gi-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      encoder_angle <= '0;
      encoder_update <= 1'b0;
    end else begin
      encoder_update <= ang_tick && (angle_now != encoder_angle);
      if (ang_tick && (angle_now != encoder_angle)) begin
        encoder_angle <= angle_now;
      end
    end
  end

  // ---------------- slow registers
  logic [ZW-1:0] zcd_cnt_q;
  logic [FW-1:0] fld_cnt_q;
  wire zcd_tick = (zcd_cnt_q == ZW'(ZCD_CYC - 1));
  wire fld_tick = (fld_cnt_q == FW'(FIELD_REFRESH_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zcd_cnt_q <= '0;
      fld_cnt_q <= '0;
      zero_cross_angle_value_q <= '0;
      field_q <= '0;
    end else begin
      zcd_cnt_q <= zcd_tick ? '0 : zcd_cnt_q + ZW'(1);
      fld_cnt_q <= fld_tick ? '0 : fld_cnt_q + FW'(1);
      if (zcd_tick) zero_cross_angle_value_q <= zero_cross_raw;
      if (fld_tick) field_q <= field_raw;
    end
  end

  // ---------------- serial readout
  ser_state_t ser_q;
  logic [2:0] lat_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [SERIAL_BITS-1:0] shift_q;
  logic sclk_q, cs_q;
  wire cs_fall = cs_q && !cs_n;
  wire sclk_fall = sclk_q && !sclk;
  wire [3:0] word_flags = {fault_flags[0], fault_flags[1], fault_flags[2],
                           |fault_flags[FAULT_N-1:3]};
  wire [SERIAL_BITS-1:0] word_narrow = {word_flags, angle_now[ANG_W-1 -: 12]};
  wire [SERIAL_BITS-1:0] word_wide = {1'b0, angle_now};
  wire [SERIAL_BITS-1:0] word_sel = angle_wide ? word_wide : word_narrow;
  wire lat_done = (lat_cnt_q == 3'(CS_LATCH_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_q <= SER_IDLE;
      lat_cnt_q <= '0;
      bit_cnt_q <= '0;
      shift_q <= '0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      miso <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      case (ser_q)
        SER_IDLE: begin
          miso <= 1'b0;
          lat_cnt_q <= '0;
          if (cs_fall) ser_q <= SER_LATCH;
        end
        SER_LATCH: begin
          lat_cnt_q <= lat_cnt_q + 3'd1;
          if (cs_n) begin
            ser_q <= SER_IDLE;
          end else if (lat_done) begin
            shift_q <= word_sel;
            miso <= word_sel[SERIAL_BITS-1];
            bit_cnt_q <= '0;
            ser_q <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (cs_n) begin
            ser_q <= SER_IDLE;
          end else if (sclk_fall) begin
            shift_q <= {shift_q[SERIAL_BITS-2:0], 1'b0};
            miso <= shift_q[SERIAL_BITS-2];
            bit_cnt_q <= bit_cnt_q + 5'd1;
            if (bit_cnt_q == 5'(SERIAL_BITS - 1)) begin
              miso <= 1'b0;
              ser_q <= SER_DONE;
            end
          end
        end
        SER_DONE: begin
          miso <= 1'b0;
          if (cs_n) ser_q <= SER_IDLE;
        end
        default: ser_q <= SER_IDLE;
      endcase
    end
  end

  // ---------------- error capture and pulse-width generation
  logic [FAULT_N-1:0] err_seen_q, err_hold_q;
  logic pwm_level, period_start;

  function automatic logic [3:0] top_fault(input logic [FAULT_N-1:0] f);
    top_fault = 4'd0;
    for (int i = FAULT_N - 1; i >= 0; i--) begin
      if (f[i]) top_fault = 4'(i);
    end
  endfunction : top_fault

  wire err_any = |err_hold_q;
  wire [3:0] err_idx = top_fault(err_hold_q);
  wire show_err = error_output_enable && err_any;
  wire freq_halve = show_err && error_signal_select;
  wire hiz_d = hiz_q || (show_err && !error_signal_select);

  wire [PER_W-1:0] per_base = band_base(carrier_band_select)
                            + PER_W'(carrier_step_select) * PER_W'(STEP_INC0 <<
                              carrier_band_select);
  wire [PER_W-1:0] per_sel = freq_halve ? {per_base[PER_W-2:0], 1'b0} : per_base;
  wire [PWM_ANG_W-1:0] pwm_angle = angle_now[ANG_W-1 -: PWM_ANG_W];
  wire [NUM_W+PWM_ANG_W-1:0] ang_span = DUTY_SPAN * (NUM_W+PWM_ANG_W)'(pwm_angle);
  wire [NUM_W-1:0] duty_ang = DUTY_LOW + NUM_W'(ang_span >> PWM_ANG_W);
  wire [NUM_W-1:0] duty_err = ERR_BASE + ERR_STEP * NUM_W'(err_idx);
  wire [NUM_W-1:0] duty_sel = freq_halve ? duty_err : duty_ang;
  wire [PER_W+NUM_W-1:0] fall_full = (PER_W+NUM_W)'(per_sel) * (PER_W+NUM_W)'(duty_sel);
  wire [PER_W+NUM_W-1:0] fall_div = fall_full / (PER_W+NUM_W)'(PCT_SCALE);
  wire [PER_W-1:0] fall_sel = fall_div[PER_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_seen_q <= '0;
      err_hold_q <= '0;
      hiz_q <= 1'b0;
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
    end else begin
      if (period_start) begin
        err_hold_q <= err_seen_q | fault_flags;
        err_seen_q <= '0;
      end else begin
        err_seen_q <= err_seen_q | fault_flags;
      end
      hiz_q <= hiz_d;
      pwm_out <= hiz_d ? 1'b0 : pwm_level;
      pwm_oe <= !hiz_d;
    end
  end

  pwm_carrier #(.W(PER_W)) u_carrier (
    .aclk(aclk),
    .aresetn(aresetn),
    .period_len(per_sel),
    .fall_point(fall_sel),
    .pwm_level(pwm_level),
    .period_start(period_start)
  );

  // ---------------- axi4-lite slave
  logic aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  wire aw_full_d = (aw_full_q || aw_hs) && !do_write;
  wire w_full_d = (w_full_q || w_hs) && !do_write;
  wire bvalid_d = do_write || (s_axi_bvalid && !s_axi_bready);
  wire wr_ctrl = do_write && (aw_addr_q == OFS_CTRL);
  wire wr_wptr = do_write && (aw_addr_q == OFS_WPTR);
  wire wr_ro = (aw_addr_q == OFS_STATUS) || (aw_addr_q == OFS_ANGLE)
            || (aw_addr_q == OFS_ZCD) || (aw_addr_q == OFS_FIELD);
  wire wr_ok = (aw_addr_q == OFS_CTRL) || (aw_addr_q == OFS_WPTR) || wr_ro;
  wire [31:0] ctrl_new = merge(32'(ctrl_q), w_data_q, w_strb_q);
  wire [31:0] wptr_new = merge(32'(wptr_q), w_data_q, w_strb_q);

  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rvalid_d = ar_hs || (s_axi_rvalid && !s_axi_rready);
  wire [31:0] status_word = {24'h000000, err_idx, 1'b0, err_any, show_err, hiz_q};
  wire rd_ok = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_WPTR)
            || (s_axi_araddr == OFS_STATUS) || (s_axi_araddr == OFS_ANGLE)
            || (s_axi_araddr == OFS_ZCD) || (s_axi_araddr == OFS_FIELD);
  wire [31:0] rd_word =
      (s_axi_araddr == OFS_CTRL) ? 32'(ctrl_q) :
      (s_axi_araddr == OFS_WPTR) ? 32'(wptr_q) :
      (s_axi_araddr == OFS_STATUS) ? status_word :
      (s_axi_araddr == OFS_ANGLE) ? 32'(angle_now) :
      (s_axi_araddr == OFS_ZCD) ? 32'(zero_cross_angle_value_q) :
      (s_axi_araddr == OFS_FIELD) ? 32'(field_q) : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= nvm_config;
      wptr_q <= WPTR_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new[CFG_W-1:0];
      if (wr_wptr) wptr_q <= wptr_new[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_hs) aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_full_d && !bvalid_d;
      s_axi_wready <= !w_full_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (do_write) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      s_axi_rvalid <= rvalid_d;
      s_axi_arready <= !rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule : angle_pwm_output
`default_nettype wire

// [verif/angle_pwm_output_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module angle_pwm_output_assertions #(
  parameter int FIELD_REFRESH_CYC = 64,
  parameter int LAT_STAGES = 10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic pwm_out,
  input wire logic pwm_oe,
  input wire logic encoder_update
);
  logic [23:0] hi_q, lo_q;
  logic run_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // run lengths of the pin levels; run_q skips the partial first low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= '0;
      lo_q <= '0;
      run_q <= 1'b0;
    end else begin
      hi_q <= pwm_out ? hi_q + 1'b1 : '0;
      lo_q <= pwm_out ? '0 : lo_q + 1'b1;
      if ($rose(pwm_out)) run_q <= 1'b1;
    end
  end
  chk_reset_quiet: assert property ($rose(aresetn) |-> !pwm_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active right after reset");
  chk_hiz_sticky: assert property ($fell(pwm_oe) |=> !pwm_oe [*8])
    else $error("pin left high impedance");
  chk_hiz_quiet: assert property (!pwm_oe |-> !pwm_out)
    else $error("level driven while released");
  chk_high_floor: assert property ($fell(pwm_out) && pwm_oe |-> hi_q >= 630)
    else $error("high time below low clamp");
  chk_low_floor: assert property ($rose(pwm_out) && run_q |-> lo_q >= 630)
    else $error("low time below high clamp");
  chk_enc_pulse: assert property (encoder_update |=> !encoder_update [*8])
    else $error("encoder update too frequent");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  cover property ($fell(pwm_oe));
  cover property (encoder_update);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : angle_pwm_output_assertions
`default_nettype wire

// [verif/host_capture_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_capture_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pulse-width pin
  input wire logic pwm_out,
  input wire logic pwm_oe,
  // serial pins
  input wire logic miso,
  output logic cs_n,
  output logic sclk
);
  int per_q, hi_q, nper_q, cnt_q, hcnt_q;
  logic pin_q;
  logic pin;
  // a released pin reads low through the host pull-down
  assign pin = pwm_oe && pwm_out;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 0;
      hcnt_q <= 0;
      nper_q <= 0;
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
      if (pin && !pin_q) begin
        per_q <= cnt_q;
        hi_q <= hcnt_q;
        nper_q <= nper_q + 1;
        cnt_q <= 1;
        hcnt_q <= 1;
      end else begin
        cnt_q <= cnt_q + 1;
        hcnt_q <= hcnt_q + int'(pin);
      end
    end
  end
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  // gap after select covers the latch window; sixteen falls per word
  task automatic read_word(output logic [15:0] w, output logic tail);
    @(posedge aclk);
    cs_n <= 1'b0;
    repeat (10) @(posedge aclk);
    for (int i = 15; i >= 0; i--) begin
      w[i] = miso;
      sclk <= 1'b0;
      repeat (3) @(posedge aclk);
      sclk <= 1'b1;
      repeat (3) @(posedge aclk);
    end
    tail = miso;
    cs_n <= 1'b1;
  endtask : read_word
endmodule : host_capture_model
`default_nettype wire

// [verif/angle_pwm_output_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module angle_pwm_output_bench;
  import angle_pwm_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cs_n, sclk, miso, pwm_out, pwm_oe, encoder_update;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [CFG_W-1:0] nvm_config;
  logic [ANG_W-1:0] angle_raw, encoder_angle;
  logic [11:0] zero_cross_raw, field_raw;
  logic [FAULT_N-1:0] fault_flags;
  int failures, samples_checked;
  angle_pwm_output #(.FIELD_REFRESH_CYC(64), .LAT_STAGES(10)) u_angle_pwm_output (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .nvm_config, .angle_raw, .zero_cross_raw, .field_raw,
    .fault_flags, .cs_n, .sclk, .miso, .pwm_out, .pwm_oe, .encoder_angle, .encoder_update);
  host_capture_model u_host_capture_model (
    .aclk, .aresetn, .pwm_out, .pwm_oe, .miso, .cs_n, .sclk);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      conclude();
    end
  endtask : give_up
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    int dly;
    n = 0;
    dly = $urandom % 3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > dly) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 64);
    s_axi_bready <= 1'b0;
    give_up(n, 64);
    check(32'(s_axi_bresp), 32'(er));
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    int dly;
    n = 0;
    dly = $urandom % 3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > dly) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 64);
    s_axi_rready <= 1'b0;
    give_up(n, 64);
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(er));
  endtask : axi_read
  task automatic wait_count(input int goal);
    int n;
    n = 0;
    while (u_host_capture_model.nper_q < goal && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    give_up(n, 40000);
  endtask : wait_count
  function automatic int exp_high(input int per, input int a12);
    return per * (5000 + 90000 * a12 / 4096) / 100000;
  endfunction : exp_high
  function automatic logic [31:0] near(input int s, input int e);
    return (s - e <= 2 && e - s <= 2) ? 32'h1 : 32'h0;
  endfunction : near
  initial begin
    logic [31:0] rd;
    logic [15:0] w;
    logic tail;
    logic [ANG_W-1:0] ang;
    logic [3:0] step;
    logic [7:0] wp;
    int per;
    int n;
    void'($urandom(32'h246cea20));
    failures = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    nvm_config = 12'h004;
    angle_raw = 15'h0007;
    zero_cross_raw = 12'($urandom);
    field_raw = 12'($urandom);
    fault_flags = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(OFS_CTRL, RESP_OKAY, rd);
    check(rd, 32'h004);
    wp = 8'($urandom);
    axi_write(OFS_WPTR, {24'h0, wp}, RESP_OKAY);
    axi_read(OFS_WPTR, RESP_OKAY, rd);
    check(rd, {24'h0, wp});
    axi_write(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
    axi_read(OFS_STATUS, RESP_OKAY, rd);
    check(rd, 32'h0);
    axi_read(8'h18, RESP_SLVERR, rd);
    axi_write(8'h1c, 32'h1, RESP_SLVERR);
    wait_count(2);
    check(near(u_host_capture_model.hi_q, 640), 32'h1);
    check(32'(u_host_capture_model.per_q), 32'd12800);
    ang = {12'hfff, 3'($urandom)};
    step = 4'($urandom);
    angle_raw <= ang;
    repeat (350) @(posedge aclk);
    check(32'(encoder_angle), 32'h0007);
    repeat (110) @(posedge aclk);
    check(32'(encoder_angle), 32'(ang));
    axi_write(OFS_CTRL, {20'h0, step, 8'h04}, RESP_OKAY);
    u_host_capture_model.read_word(w, tail);
    check(32'(w), 32'(ang));
    check(32'(tail), 32'h0);
    axi_read(OFS_ANGLE, RESP_OKAY, rd);
    check(rd, 32'(ang));
    axi_read(OFS_ZCD, RESP_OKAY, rd);
    check(rd, 32'(zero_cross_raw));
    axi_read(OFS_FIELD, RESP_OKAY, rd);
    check(rd, 32'(field_raw));
    axi_write(OFS_CTRL, {20'h0, step, 8'h00}, RESP_OKAY);
    u_host_capture_model.read_word(w, tail);
    check(32'(w), {20'h0, ang[14:3]});
    fault_flags <= 13'h001;
    repeat (5) @(posedge aclk);
    fault_flags <= '0;
    wait_count(4);
    per = 12800 + 100 * int'(step);
    check(32'(u_host_capture_model.per_q), 32'(per));
    check(near(u_host_capture_model.hi_q, exp_high(per, 4095)), 32'h1);
    // let the held watchdog fault drain so only the brief fault below can latch
    wait_count(5);
    axi_write(OFS_CTRL, 32'h001, RESP_OKAY);
    fault_flags <= 13'h010;
    repeat (3) @(posedge aclk);
    fault_flags <= '0;
    n = 0;
    while (pwm_oe && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    give_up(n, 40000);
    repeat (2000) @(posedge aclk);
    check(32'(pwm_oe), 32'h0);
    axi_read(OFS_STATUS, RESP_OKAY, rd);
    check(32'(rd[0]), 32'h1);
    check(32'(rd[7:0]), 32'h47);
    nvm_config <= 12'($urandom) & 12'hf77;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'(pwm_oe), 32'h1);
    axi_read(OFS_WPTR, RESP_OKAY, rd);
    check(rd, 32'h0);
    axi_read(OFS_CTRL, RESP_OKAY, rd);
    check(rd, 32'(nvm_config));
    conclude();
  end
endmodule : angle_pwm_output_bench
bind angle_pwm_output angle_pwm_output_assertions #(
  .FIELD_REFRESH_CYC(FIELD_REFRESH_CYC), .LAT_STAGES(LAT_STAGES)) u_angle_pwm_output_assertions (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out, .pwm_oe, .encoder_update);
`default_nettype wire
